// [core/meas_port_params.svh]
/*
  Constants of the parallel measurement output port: register offsets,
  field positions, reset values and timing counts.
  Assumes a 50 MHz clock; all counts are derived from it.
*/
`ifndef MEAS_PORT_PARAMS_SVH
`define MEAS_PORT_PARAMS_SVH

`define CLK_PERIOD_NS     20
`define BASE_PERIOD_NS    20000
`define SETUP_NS          1600
`define STROBE_NS         6000
`define TRIG_MAX_NS       30000
`define BASE_CYC          ((`BASE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC         ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC        ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRIG_MAX_CYC      (`TRIG_MAX_NS / `CLK_PERIOD_NS)

`define AVG_EXP_FREE_MAX  5'h0b
`define AVG_EXP_MAX       5'h11

`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_MASK          8'h08
`define REG_LIVE          8'h0c
`define CTRL_AVG_LSB      0
`define CTRL_SUM_BIT      8
`define CTRL_RESET        32'h0000_0000
`define MASK_RESET        3'h0

`define EV_STROBE         0
`define EV_TRIGGER        1
`define EV_ALARM          2
`define EV_COUNT          3

`endif

// [core/meas_port_pkg.sv]
/*
  Types and the period function of the measurement output port.
  Assumes the constants header is on the include path.
*/
`include "meas_port_params.svh"

package meas_port_pkg;

  // Alarm bits: 0 high, 1 low, 2 +area, 3 -area, 4 bright, 5 dark, 6 error, 7 go
  typedef struct packed {
    logic [15:0] disp;
    logic [15:0] inten;
    logic [7:0]  alarm;
  } meas_s;

  function automatic logic [7:0] period_ticks(input logic [4:0] avg_exp,
                                              input logic       sum_mode);
    logic [2:0] sh;
    sh = (avg_exp > `AVG_EXP_FREE_MAX) ? 3'(avg_exp - `AVG_EXP_FREE_MAX) : 3'h0;
    return 8'(8'h01 << (sh + {2'h0, sum_mode}));
  endfunction

endpackage

// [core/interval_timer.sv]
/*
  Loadable down counter that reports busy and a one-cycle done pulse.
  Assumes the load value is at least one.
*/
`timescale 1ns/100ps

module interval_timer #(parameter int WIDTH = 10)
(
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_start,
  input  wire logic [WIDTH-1:0] i_load,
  output logic                  o_busy,
  output logic                  o_done
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic             busy_reg;
  logic             busy_next;

  assign o_done    = busy_reg && (cnt_reg == WIDTH'(1));
  assign o_busy    = busy_reg;
  assign cnt_next  = i_start ? i_load : (busy_reg ? cnt_reg - WIDTH'(1) : cnt_reg);
  assign busy_next = i_start | (busy_reg & ~o_done);

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end

endmodule

// [core/event_status.sv]
/*
  Sticky event bits, a mask and one level interrupt.
  Assumes the clear comes from a read of the status word; a set wins.
*/
`timescale 1ns/100ps

module event_status #(parameter int WIDTH = 3)
(
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic             i_clear,
  input  wire logic [WIDTH-1:0] i_mask,
  output logic      [WIDTH-1:0] o_status,
  output logic                  o_irq
);

  logic [WIDTH-1:0] status_reg;
  logic [WIDTH-1:0] status_next;

  assign status_next = (i_clear ? '0 : status_reg) | i_set;
  assign o_status    = status_reg;
  assign o_irq       = |(status_reg & i_mask);

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

endmodule

// [core/measurement_output_port.sv]
/*
  Parallel measurement output port: displacement and intensity words,
  alarm lines, combined alarm and a strobe, free-running or gated by an
  external trigger, with an APB register slave and an interrupt.
  Assumes all pin inputs are synchronous to i_clk and the gate input is
  pulled high outside the chip when left open.
*/
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
`include "meas_port_params.svh"

module measurement_output_port
(
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [7:0]           i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  input  wire meas_port_pkg::meas_s i_meas,
  input  wire logic                 i_trigger_gate_n,
  input  wire logic                 i_ext_trigger_n,
  output logic      [15:0]          o_displacement_word,
  output logic      [15:0]          o_intensity_word,
  output logic      [7:0]           o_alarm_n,
  output logic                      o_alarm_or_n,
  output logic                      o_data_valid_pulse_n,
  output logic                      o_irq
);

  localparam int SETUP_WAIT = `SETUP_CYC + 1;
  localparam int TRIG_WAIT  = 1000;

  logic [4:0]               avg_exp_reg;
  logic [4:0]               avg_exp_next;
  logic                     sum_mode_reg;
  logic                     sum_mode_next;
  logic [`EV_COUNT-1:0]     mask_reg;
  logic [`EV_COUNT-1:0]     mask_next;
  logic [31:0]              prdata_reg;
  logic [31:0]              prdata_next;
  logic                     trig_prev_reg;
  logic                     pend_reg;
  logic                     pend_next;
  logic [7:0]               per_cnt_reg;
  logic [7:0]               per_cnt_next;
  meas_port_pkg::meas_s     out_reg;
  meas_port_pkg::meas_s     out_next;
  logic                     alarm_or_reg;
  logic                     alarm_or_next;
  logic [`EV_COUNT-1:0]     status;
  logic [`EV_COUNT-1:0]     ev_set;

  // Register decode
  wire       apb_setup  = i_psel & ~i_penable;
  wire       apb_access = i_psel & i_penable;
  wire       sel_ctrl   = i_paddr == `REG_CTRL;
  wire       sel_status = i_paddr == `REG_STATUS;
  wire       sel_mask   = i_paddr == `REG_MASK;
  wire       sel_live   = i_paddr == `REG_LIVE;
  wire       mapped     = sel_ctrl | sel_status | sel_mask | sel_live;
  wire       wr_ctrl    = apb_access & i_pwrite & sel_ctrl;
  wire       wr_mask    = apb_access & i_pwrite & sel_mask;
  wire       rd_clear   = apb_access & ~i_pwrite & sel_status;
  wire [4:0] wr_exp     = i_pwdata[`CTRL_AVG_LSB +: 5];

  // Sequencing
  wire       tick_busy;
  wire       tick;
  wire       setup_busy;
  wire       setup_done;
  wire       strobe_busy;
  wire       seq_busy   = setup_busy | strobe_busy;
  wire       gated      = ~i_trigger_gate_n;
  wire       trig_fall  = gated & trig_prev_reg & ~i_ext_trigger_n;
  wire [7:0] period     = meas_port_pkg::period_ticks(avg_exp_reg, sum_mode_reg);
  wire       boundary   = tick & (per_cnt_reg == period - 8'h01);
  wire       free_go    = tick & ~gated & ~seq_busy;
  wire       trig_go    = gated & (trig_fall | pend_reg) & ~seq_busy;
  wire       seq_start  = free_go | trig_go;
  wire       load_data  = (free_go & boundary) | trig_go;
  wire       alarm_load = load_data | (gated & boundary);
  wire       alarm_any  = |(~out_next.alarm[6:0]);
  wire [31:0] live_word = {27'h0, i_trigger_gate_n, i_ext_trigger_n, seq_busy,
                           o_data_valid_pulse_n, o_alarm_or_n};
  wire [31:0] ctrl_word = {23'h0, sum_mode_reg, 3'h0, avg_exp_reg};
  // An event set in the setup cycle is reported, since the access edge clears it
  wire [31:0] rd_mux    = sel_ctrl   ? ctrl_word :
                          sel_status ? {29'h0, status | ev_set} :
                          sel_mask   ? {29'h0, mask_reg} :
                          sel_live   ? live_word : 32'h0;

  // Zero wait states; unmapped addresses answer with an error
  assign o_pready  = 1'b1;
  assign o_pslverr = apb_access & ~mapped;
  assign o_prdata  = prdata_reg;

  // Out-of-range averaging settings clamp to the longest period
  assign avg_exp_next  = wr_ctrl ? ((wr_exp > `AVG_EXP_MAX) ? `AVG_EXP_MAX : wr_exp)
                                 : avg_exp_reg;
  assign sum_mode_next = wr_ctrl ? i_pwdata[`CTRL_SUM_BIT] : sum_mode_reg;
  assign mask_next     = wr_mask ? i_pwdata[`EV_COUNT-1:0] : mask_reg;
  assign prdata_next   = apb_setup ? rd_mux : prdata_reg;

  // A trigger that arrives mid-strobe waits, so words never move under it
  assign pend_next     = gated & ~trig_go & (pend_reg | trig_fall);

  // Period in 20 us ticks grows with averaging and sum mode; a new setting
  // restarts the count so a shorter period is never overrun
  assign per_cnt_next  = wr_ctrl ? 8'h00 :
                         !tick ? per_cnt_reg :
                         boundary ? 8'h00 : per_cnt_reg + 8'h01;

  // Alarms are captured with the data words, and also at each period boundary while gated
  assign out_next.disp  = load_data ? i_meas.disp  : out_reg.disp;
  assign out_next.inten = load_data ? i_meas.inten : out_reg.inten;
  assign out_next.alarm = alarm_load ? ~i_meas.alarm : out_reg.alarm;
  assign alarm_or_next  = ~alarm_any;

  assign o_displacement_word  = out_reg.disp;
  assign o_intensity_word     = out_reg.inten;
  assign o_alarm_n            = out_reg.alarm;
  assign o_alarm_or_n         = alarm_or_reg;
  assign o_data_valid_pulse_n = ~strobe_busy;

  assign ev_set[`EV_STROBE]  = setup_done;
  assign ev_set[`EV_TRIGGER] = trig_go;
  assign ev_set[`EV_ALARM]   = alarm_or_reg & ~alarm_or_next;

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      avg_exp_reg   <= 5'(`CTRL_RESET);
      sum_mode_reg  <= 1'b0;
      mask_reg      <= `MASK_RESET;
      prdata_reg    <= 32'h0;
      trig_prev_reg <= 1'b1;
      pend_reg      <= 1'b0;
      per_cnt_reg   <= 8'h00;
      out_reg       <= {16'h0, 16'h0, 8'hff};
      alarm_or_reg  <= 1'b1;
    end
    else
    begin
      avg_exp_reg   <= avg_exp_next;
      sum_mode_reg  <= sum_mode_next;
      mask_reg      <= mask_next;
      prdata_reg    <= prdata_next;
      trig_prev_reg <= i_ext_trigger_n;
      pend_reg      <= pend_next;
      per_cnt_reg   <= per_cnt_next;
      out_reg       <= out_next;
      alarm_or_reg  <= alarm_or_next;
    end
  end

  // 20 us base tick, free running
  interval_timer #(.WIDTH(10)) u_tick
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_start   (~tick_busy | tick),
    .i_load    (10'(`BASE_CYC)),
    .o_busy    (tick_busy),
    .o_done    (tick)
  );

  // Data settle time before the strobe edge
  interval_timer #(.WIDTH(10)) u_setup
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_start   (seq_start),
    .i_load    (10'(`SETUP_CYC)),
    .o_busy    (setup_busy),
    .o_done    (setup_done)
  );

  interval_timer #(.WIDTH(10)) u_strobe
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_start   (setup_done),
    .i_load    (10'(`STROBE_CYC)),
    .o_busy    (strobe_busy),
    .o_done    ()
  );

  event_status #(.WIDTH(`EV_COUNT)) u_events
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_set     (ev_set),
    .i_clear   (rd_clear),
    .i_mask    (mask_reg),
    .o_status  (status),
    .o_irq     (o_irq)
  );

  // Checking helpers
  logic [9:0]  low_cnt_reg;
  logic [10:0] gap_cnt_reg;
  logic        free_only_reg;

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      low_cnt_reg   <= 10'h000;
      gap_cnt_reg   <= 11'h000;
      free_only_reg <= 1'b0;
    end
    else
    begin
      low_cnt_reg   <= o_data_valid_pulse_n ? 10'h000 : low_cnt_reg + 10'h001;
      gap_cnt_reg   <= setup_done ? 11'h001 : gap_cnt_reg + 11'h001;
      free_only_reg <= setup_done ? ~gated : (free_only_reg & ~gated);
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  chk_strobe_width: assert property (
    $rose(o_data_valid_pulse_n) |-> low_cnt_reg == 10'(`STROBE_CYC))
    else $error("strobe width wrong");

  chk_setup_delay: assert property (
    load_data |-> ##SETUP_WAIT $fell(o_data_valid_pulse_n))
    else $error("strobe not after setup time");

  chk_word_capture: assert property (
    load_data |=> (o_displacement_word == $past(i_meas.disp)) &&
                  (o_intensity_word == $past(i_meas.inten)))
    else $error("words not captured");

  chk_alarm_lines: assert property (
    alarm_load |=> o_alarm_n == ~$past(i_meas.alarm))
    else $error("alarm lines not active low");

  chk_alarm_or: assert property (
    ##1 (o_alarm_or_n == ~|(~o_alarm_n[6:0])))
    else $error("combined alarm wrong");

  chk_free_gap: assert property (
    setup_done && free_only_reg && !gated && gap_cnt_reg != 11'h000
      |-> gap_cnt_reg == 11'(`BASE_CYC))
    else $error("free strobe not every base period");

  chk_free_period: assert property (
    free_go |-> load_data == (per_cnt_reg ==
      meas_port_pkg::period_ticks(avg_exp_reg, sum_mode_reg) - 8'h01))
    else $error("free data period wrong");

  chk_gated_quiet: assert property (
    load_data && gated |-> trig_go)
    else $error("gated data without trigger");

  chk_trig_latency: assert property (
    trig_fall |-> ##[1:TRIG_WAIT] (setup_done || !gated))
    else $error("trigger not answered in time");

  chk_words_stable: assert property (
    !load_data |=> $stable(o_displacement_word) && $stable(o_intensity_word))
    else $error("words moved without load");

  chk_gated_alarm: assert property (
    gated && boundary |=> o_alarm_n == ~$past(i_meas.alarm))
    else $error("gated alarm refresh missing");

  // Sequencing, status, clamp and bus hold checks
  chk_setup_quiet: assert property (
    setup_busy |-> o_data_valid_pulse_n)
    else $error("strobe low during setup");

  chk_no_overlap: assert property (
    setup_done |-> !strobe_busy)
    else $error("sequences overlap");

  chk_pend_hold: assert property (
    pend_reg && gated && seq_busy |=> pend_reg)
    else $error("pending trigger lost");

  chk_pend_start: assert property (
    pend_reg && gated && !seq_busy |=> setup_busy)
    else $error("pending trigger not started");

  chk_trig_ignored: assert property (
    !gated |=> !pend_reg)
    else $error("trigger kept while free running");

  chk_alarm_hold: assert property (
    !alarm_load |=> $stable(o_alarm_n))
    else $error("alarm lines moved without load");

  chk_or_hold: assert property (
    !alarm_load |=> $stable(o_alarm_or_n))
    else $error("combined alarm moved without load");

  chk_status_sticky: assert property (
    ev_set[`EV_STROBE] |=> status[`EV_STROBE])
    else $error("strobe event lost");

  chk_status_clear: assert property (
    rd_clear && (ev_set == '0) |=> status == '0)
    else $error("status not cleared by read");

  chk_ctrl_clamp: assert property (
    wr_ctrl |=> !(avg_exp_reg > `AVG_EXP_MAX))
    else $error("averaging setting out of range");

  chk_prdata_hold: assert property (
    !apb_setup |=> $stable(o_prdata))
    else $error("read data moved outside setup");

  cov_free_strobe: cover property (setup_done && !gated);
  cov_gated_trig:  cover property (trig_go ##[1:100] setup_done);
  cov_sum_load:    cover property (sum_mode_reg && free_go && load_data);
  cov_pending:     cover property (pend_reg ##1 trig_go);
  cov_status_clr:  cover property (rd_clear ##1 !o_irq);

endmodule

// [test/strobe_receiver.sv]
/*
  Far-side receiver: captures the words and alarm lines on the falling
  strobe edge and flags any change while the strobe is low.
  Assumes every input is synchronous to i_clk.
*/
`timescale 1ns/100ps

module strobe_receiver
(
  input  wire logic        i_clk,
  input  wire logic        i_strobe_n,
  input  wire logic [15:0] i_disp,
  input  wire logic [15:0] i_inten,
  input  wire logic [7:0]  i_alarm_n,
  output logic      [39:0] o_sample,
  output int               o_count,
  output logic             o_moved
);
  logic        strobe_q;
  logic [39:0] bus;

  assign bus = {i_disp, i_inten, i_alarm_n};

  initial
  begin
    strobe_q = 1'b1;
    o_count  = 0;
    o_moved  = 1'b0;
    o_sample = '0;
  end

  // Sample only on the falling edge; a move while low would corrupt it
  always @(posedge i_clk)
  begin
    if (strobe_q && !i_strobe_n)
    begin
      o_sample <= bus;
      o_count  <= o_count + 1;
    end
    if (!strobe_q && !i_strobe_n && bus != o_sample)
      o_moved <= 1'b1;
    strobe_q <= i_strobe_n;
  end
endmodule

// [test/tb_top.sv]
/*
  Self-checking bench of the measurement output port.
  Assumes the design package and constants header are compiled first.
*/
`timescale 1ns/100ps

module tb_top;
  logic                 clk;
  logic                 reset_n;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  meas_port_pkg::meas_s meas;
  logic                 gate_n;
  logic                 trig_n;
  logic [15:0]          disp;
  logic [15:0]          inten;
  logic [7:0]           alarm_n;
  logic                 alarm_or_n;
  logic                 stb_n;
  logic                 irq;
  logic [39:0]          sample;
  int                   rx_count;
  logic                 moved;
  logic                 ramp;
  int                   failures;
  int                   checks;

  measurement_output_port dut
  (
    .i_clk(clk), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_meas(meas),
    .i_trigger_gate_n(gate_n), .i_ext_trigger_n(trig_n),
    .o_displacement_word(disp), .o_intensity_word(inten), .o_alarm_n(alarm_n),
    .o_alarm_or_n(alarm_or_n), .o_data_valid_pulse_n(stb_n), .o_irq(irq)
  );

  strobe_receiver rx
  (
    .i_clk(clk), .i_strobe_n(stb_n), .i_disp(disp), .i_inten(inten),
    .i_alarm_n(alarm_n), .o_sample(sample), .o_count(rx_count), .o_moved(moved)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Ramp makes every load visible as a word change
  always @(posedge clk)
    if (ramp)
      meas.disp <= meas.disp + 16'h0001;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Kind 0: strobe fall, 1: strobe rise, 2: word change; bounded wait
  task automatic wait_ev(input int kind, output int n);
    logic        s0;
    logic [15:0] d0;
    logic        hit;
    s0 = stb_n;
    d0 = disp;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      hit = (kind == 0) ? (s0 === 1'b1 && stb_n === 1'b0) :
            (kind == 1) ? (s0 === 1'b0 && stb_n === 1'b1) : (disp !== d0);
      s0 = stb_n;
    end while (!hit && n < 5000);
    if (!hit)
      check("event", 32'h0, 32'h1);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_alarms();
    int          n;
    logic [7:0]  a;
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 9; i++)
    begin
      a = (i < 8) ? 8'(8'h01 << i) : 8'h00;
      meas <= '{disp: 16'(16'h8000 + i), inten: 16'h7ffe, alarm: a};
      wait_ev(2, n);
      wait_ev(0, n);
      check("setup", n, 80);
      check("disp", disp, 16'h8000 + i);
      check("inten", inten, 16'h7ffe);
      check("alarm", alarm_n, 8'(~a));
      check("alarm_or", alarm_or_n, (a[6:0] == 7'h00));
      // The receiver's capture lands one edge after the fall
      @(posedge clk);
      check("sample_words", sample[39:8], {disp, inten});
      check("sample_alarm", sample[7:0], alarm_n);
    end
    // Measure a whole strobe from its own falling edge
    wait_ev(0, n);
    wait_ev(1, n);
    check("width", n, 300);
    wait_ev(0, n);
    check("gap", n, 700);
    check("moved", moved, 1'b0);
    apb(1'b1, 8'h08, 32'h1, q, e);
    wait_ev(0, n);
    repeat (2) @(posedge clk);
    check("irq_set", irq, 1'b1);
    apb(1'b0, 8'h04, 32'h0, q, e);
    check("status", q[2:0], 3'h5);
    @(posedge clk);
    check("irq_clr", irq, 1'b0);
    apb(1'b1, 8'h08, 32'h0, q, e);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check("unmapped", {q[30:0], e}, 32'h1);
  endtask

  task automatic t_periods();
    int          n;
    int          c0;
    logic [31:0] q;
    logic        e;
    int          cfg[6] = '{32'h000, 32'h00b, 32'h00c, 32'h00d, 32'h100, 32'h10c};
    int          per[6] = '{1000, 1000, 2000, 4000, 2000, 4000};
    ramp <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, 8'h00, cfg[i], q, e);
      apb(1'b0, 8'h00, 32'h0, q, e);
      check("ctrl", q, cfg[i]);
      wait_ev(2, n);
      c0 = rx_count;
      wait_ev(2, n);
      check("period", n, per[i]);
      check("strobes", rx_count - c0, per[i] / 1000);
    end
    ramp <= 1'b0;
    apb(1'b1, 8'h00, 32'h0, q, e);
  endtask

  task automatic t_gated();
    int          n;
    int          c0;
    logic [31:0] q;
    logic        e;
    gate_n <= 1'b0;
    meas   <= '{disp: 16'h1234, inten: 16'h0002, alarm: 8'h00};
    repeat (2000) @(posedge clk);
    c0 = rx_count;
    trig_n <= 1'b0;
    wait_ev(2, n);
    check("trig_lat", n <= 1500, 1'b1);
    check("trig_disp", disp, 16'h1234);
    trig_n <= 1'b1;
    meas   <= '{disp: 16'h4321, inten: 16'h0002, alarm: 8'h04};
    repeat (3000) @(posedge clk);
    check("hold", disp, 16'h1234);
    check("refresh", alarm_n, 8'hfb);
    check("one_out", rx_count - c0, 1);
    apb(1'b0, 8'h04, 32'h0, q, e);
    check("trig_event", q[1], 1'b1);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    check("live", q, 32'h0000_000a);
    gate_n <= 1'b1;
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #2000000;
    failures++;
    give_verdict();
  end

  initial
  begin
    failures = 0;
    checks   = 0;
    ramp     = 1'b0;
    reset_n  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    meas     = '0;
    gate_n   = 1'b1; // Open gate pin reads high
    trig_n   = 1'b1;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check("idle_alarm", {alarm_n, alarm_or_n, stb_n}, 10'h3ff);
    t_alarms();
    t_periods();
    t_gated();
    give_verdict();
  end
endmodule
